/* File: verification/dsol_chk_sva.sv */
// Purpose: Concurrent checks on the status output ports.
// Assumes: Bound to dsol_top; one clock domain.
// Notes: Terminal defaults are checked until a selector is written.
`timescale 1ns/1ps

module dsol_chk_sva
    import dsol_pkg::*;
(
    // Clock and reset
    input wire logic I_MCLK,
    input wire logic I_SYS_RST,
    // Register port
    input wire logic [DSOL_ADDR_W-1:0] I_ADDR,
    input wire logic [DSOL_DATA_W-1:0] I_WDATA,
    input wire logic I_WR,
    input wire logic I_RD,
    input wire logic [DSOL_DATA_W-1:0] O_RDATA,
    // Core and pins
    input wire dsol_core_t I_CORE,
    input wire logic I_OUTPUT_SHUTOFF,
    input wire dsol_flags_t O_FLAGS,
    input wire logic [DSOL_NUM_TERM-1:0] O_TERM_ON
);
    default clocking @(posedge I_MCLK); endclocking
    default disable iff (I_SYS_RST);

    logic sel_a_set_q;
    logic sel_b_set_q;

    always_ff @(posedge I_MCLK or posedge I_SYS_RST)
        if (I_SYS_RST) sel_a_set_q <= 1'b0;
        else if (I_WR && I_ADDR == DSOL_OFF_SELECT_A) sel_a_set_q <= 1'b1;

    always_ff @(posedge I_MCLK or posedge I_SYS_RST)
        if (I_SYS_RST) sel_b_set_q <= 1'b0;
        else if (I_WR && I_ADDR == DSOL_OFF_SELECT_B) sel_b_set_q <= 1'b1;

    // ************************************************************
    // Sequences and assertions
    // ************************************************************
    sequence s_ready_ok;
        (I_CORE.init_done && !I_CORE.trip && !I_CORE.power_fail && !I_CORE.undervolt
            && !I_OUTPUT_SHUTOFF)[*4];
    endsequence

    sequence s_shutoff_held;
        I_OUTPUT_SHUTOFF[*3];
    endsequence

    AST_TRIP_ALARM: assert property (I_CORE.trip |=> O_FLAGS.trip_alarm_flag)
        else $error("trip alarm flag missing after trip");
    AST_READY_LOSS: assert property ((I_CORE.power_fail || I_CORE.undervolt)
        |=> !O_FLAGS.operation_ready_flag) else $error("ready flag during supply loss");
    AST_READY_ON: assert property (s_ready_ok |=> O_FLAGS.operation_ready_flag)
        else $error("ready flag missing");
    AST_SHUTOFF: assert property (s_shutoff_held |=>
        !O_FLAGS.operation_ready_flag && !O_FLAGS.motor_active_flag)
        else $error("flags on during shutoff");
    AST_BRAKE: assert property (I_CORE.dc_brake |=> !O_FLAGS.at_speed_flag
        && !O_FLAGS.freq_threshold_flag && !O_FLAGS.motor_active_flag)
        else $error("frequency flag on during braking");
    AST_STOPPED: assert property (I_CORE.out_freq == 16'h0000
        |=> !O_FLAGS.motor_active_flag) else $error("motor active while stopped");
    AST_FAULT_LIST: assert property (I_CORE.trip
        && I_CORE.fault_code inside {[8'h01:8'h06]} |=> O_FLAGS.internal_fault_flag)
        else $error("internal fault flag missing");
    AST_GND_AS_OC: assert property (I_CORE.trip && I_CORE.ground_fault_seen
        && I_CORE.fault_code == DSOL_FLT_ACCEL_OC |=> O_FLAGS.internal_fault_flag)
        else $error("internal fault flag missing on ground fault");
    AST_TERM_A_DEFAULT: assert property (!sel_a_set_q
        |=> O_TERM_ON[0] == $past(O_FLAGS.motor_active_flag))
        else $error("open collector terminal not following motor active");
    AST_TERM_B_DEFAULT: assert property (!sel_b_set_q
        |=> O_TERM_ON[1] == $past(O_FLAGS.trip_alarm_flag))
        else $error("relay terminal not following trip alarm");
    AST_RDATA_IDLE: assert property (!I_RD |=> O_RDATA == 32'h00000000)
        else $error("read data outside read cycle");
endmodule

bind dsol_top dsol_chk_sva chk_u (.I_MCLK(I_MCLK), .I_SYS_RST(I_SYS_RST), .I_ADDR(I_ADDR),
    .I_WDATA(I_WDATA), .I_WR(I_WR), .I_RD(I_RD), .O_RDATA(O_RDATA), .I_CORE(I_CORE),
    .I_OUTPUT_SHUTOFF(I_OUTPUT_SHUTOFF), .O_FLAGS(O_FLAGS), .O_TERM_ON(O_TERM_ON));

/* File: verification/dsol_term_watch.sv */
// Purpose: External equipment reading the two output terminals.
// Assumes: Open collector line has a pull-up; relay closes when on.
// Notes: Gives the line levels that the far side would see.
`timescale 1ns/1ps

module dsol_term_watch
(
    // Terminals
    input wire logic [1:0] i_term,
    // Line levels
    output logic o_line_a,
    output logic o_line_b
);
    // Conducting collector pulls the line low
    assign o_line_a = i_term[0] ? 1'b0 : 1'b1;
    assign o_line_b = i_term[1];
endmodule

/* File: verification/testbench.sv */
// Purpose: Self-checking bench for the drive status output logic.
// Assumes: Settings held in shadow copies for expectations.
// Notes: Expected flags are derived from core inputs and settings.
`timescale 1ns/1ps

module testbench;
    import dsol_pkg::*;
    logic mclk = 1'b0;
    logic sys_rst = 1'b1;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic shutoff = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h00000000;
    logic [31:0] rdata;
    dsol_core_t core = '0;
    dsol_core_t c;
    dsol_flags_t flags;
    dsol_flags_t ef;
    logic [1:0] term;
    logic line_a;
    logic line_b;
    logic [31:0] band = 32'hA;
    logic [31:0] fwd = 32'h3C;
    logic [31:0] rev = 32'h270F;
    logic [31:0] st = 32'h5;
    logic [15:0] codes [6] = '{16'h0, 16'h1, 16'h4, 16'hB, 16'h5B, 16'h63};
    int bits [6] = '{1, 4, 5, 0, 3, 2};
    int bad_count = 0;
    int n_checks = 0;

    always #5 mclk = ~mclk;

    dsol_top dut_u (.I_MCLK(mclk), .I_SYS_RST(sys_rst), .I_ADDR(addr), .I_WDATA(wdata),
        .I_WR(wr), .I_RD(rd), .O_RDATA(rdata), .I_CORE(core), .I_OUTPUT_SHUTOFF(shutoff),
        .O_FLAGS(flags), .O_TERM_ON(term));
    dsol_term_watch watch_u (.i_term(term), .o_line_a(line_a), .o_line_b(line_b));

    // ************************************************************
    // Tasks
    // ************************************************************
    function automatic dsol_flags_t expf(input dsol_core_t v);
        dsol_flags_t f;
        logic [31:0] th;
        logic [31:0] d;
        th = (v.rev_dir && rev != 32'h270F) ? rev : fwd;
        d = v.out_freq > v.set_freq ? v.out_freq - v.set_freq : v.set_freq - v.out_freq;
        f.operation_ready_flag = v.init_done & !v.trip & !shutoff & !v.power_fail & !v.undervolt;
        f.motor_active_flag = v.out_freq >= st && v.out_freq != 0 && !v.dc_brake && !v.trip
            && !shutoff;
        f.trip_alarm_flag = v.trip;
        f.internal_fault_flag = v.trip && (v.fault_code inside {[8'h01:8'h06]}
            || (v.fault_code == 8'h07 && v.ground_fault_seen));
        f.at_speed_flag = !v.dc_brake && d * 100 <= v.set_freq * band;
        f.freq_threshold_flag = !v.dc_brake && v.out_freq >= th;
        return f;
    endfunction

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge mclk);
        wr <= 1'b0;
        case (a)
            DSOL_OFF_AT_SPEED_BAND: if (d <= 100) band = d;
            DSOL_OFF_FWD_THRESH: if (d <= 4000) fwd = d;
            DSOL_OFF_REV_THRESH: if (d <= 4000 || d == 9999) rev = d;
            DSOL_OFF_START_FREQ: if (d <= 4000) st = d;
            default: ;
        endcase
    endtask

    task automatic rd_reg(input logic [7:0] a, input logic [31:0] e);
        @(posedge mclk);
        rd <= 1'b1;
        addr <= a;
        @(posedge mclk);
        rd <= 1'b0;
        #1 chk(rdata, e);
    endtask

    task automatic go(input dsol_core_t v);
        @(posedge mclk);
        core <= v;
        repeat (5) @(posedge mclk);
        #1 chk(32'(flags), 32'(expf(v)));
        chk(32'(line_a), 32'(!term[0]));
        chk(32'(line_b), 32'(term[1]));
    endtask

    task automatic two(input logic [15:0] a, input logic [15:0] b);
        c.out_freq = a;
        go(c);
        c.out_freq = b;
        go(c);
    endtask

    task automatic wrap_up;
        if (bad_count == 0 && n_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    initial
    begin
        #200000;
        bad_count++;
        wrap_up;
    end

    // ************************************************************
    // Tests
    // ************************************************************
    initial
    begin
        repeat (10) @(posedge mclk);
        sys_rst <= 1'b0;
        rd_reg(DSOL_OFF_AT_SPEED_BAND, 32'h0000000A);
        rd_reg(DSOL_OFF_FWD_THRESH, 32'h0000003C);
        rd_reg(DSOL_OFF_REV_THRESH, 32'h0000270F);
        rd_reg(DSOL_OFF_START_FREQ, 32'h00000005);
        rd_reg(DSOL_OFF_SELECT_A, 32'h00000000);
        rd_reg(DSOL_OFF_SELECT_B, 32'h00000063);
        rd_reg(8'h1C, 32'h00000000);
        wr_reg(DSOL_OFF_STATUS, 32'h000000FF);
        rd_reg(DSOL_OFF_STATUS, 32'(expf(core)));
        c = '0;
        c.init_done = 1'b1;
        c.set_freq = 16'h03E8;
        two(16'h0064, 16'h03E8);
        chk(32'(term), 32'h1);
        c.trip = 1'b1;
        c.fault_code = DSOL_FLT_PROCESSOR;
        go(c);
        chk(32'(term), 32'h2);
        for (int s = 0; s < 2; s++)
        begin
            c.trip = s[0];
            go(c);
            ef = expf(c);
            for (int i = 0; i < 6; i++)
            begin
                wr_reg(DSOL_OFF_SELECT_A, 32'(codes[i]));
                wr_reg(DSOL_OFF_SELECT_B, 32'(codes[i]) + 100);
                go(c);
                chk(32'(term), {30'h0, !ef[bits[i]], ef[bits[i]]});
                wr_reg(DSOL_OFF_SELECT_B, 32'(codes[i]));
                go(c);
                chk(32'(term), {30'h0, ef[bits[i]], ef[bits[i]]});
            end
        end
        wr_reg(DSOL_OFF_SELECT_A, 32'h000000C8);
        rd_reg(DSOL_OFF_SELECT_A, 32'(codes[5]));
        c.trip = 1'b0;
        two(16'h0384, 16'h0383);
        two(16'h044C, 16'h044D);
        wr_reg(DSOL_OFF_AT_SPEED_BAND, 32'h00000000);
        two(16'h03E8, 16'h03E9);
        two(16'h003B, 16'h003C);
        two(16'h0004, 16'h0005);
        c.rev_dir = 1'b1;
        wr_reg(DSOL_OFF_REV_THRESH, 32'h000000C8);
        two(16'h00C7, 16'h00C8);
        wr_reg(DSOL_OFF_REV_THRESH, 32'h0000270F);
        two(16'h003B, 16'h003C);
        wr_reg(DSOL_OFF_FWD_THRESH, 32'h00000FA1);
        rd_reg(DSOL_OFF_FWD_THRESH, 32'h0000003C);
        c.dc_brake = 1'b1;
        go(c);
        c.dc_brake = 1'b0;
        c.power_fail = 1'b1;
        go(c);
        c.power_fail = 1'b0;
        c.undervolt = 1'b1;
        go(c);
        c.undervolt = 1'b0;
        c.trip = 1'b1;
        for (int k = 0; k < 18; k++)
        begin
            c.fault_code = (k < 16) ? 8'(k / 2) : 8'hFF;
            c.ground_fault_seen = k[0];
            go(c);
        end
        c.trip = 1'b0;
        @(posedge mclk) shutoff <= 1'b1;
        go(c);
        @(posedge mclk) shutoff <= 1'b0;
        go(c);
        wrap_up;
    end
endmodule

/* File: verilog/dsol_pkg.sv */
// Purpose: Shared constants and types for the drive status output logic.
// Assumes: Frequencies are in 0.1 Hz steps; band is a whole percentage.
// Notes: Register offsets are byte addresses of aligned 32-bit words.

package dsol_pkg;

    // ************************************************************
    // Register bus geometry
    // ************************************************************
    localparam int DSOL_ADDR_W = 8;
    localparam int DSOL_DATA_W = 32;
    localparam int DSOL_FREQ_W = 16;
    localparam int DSOL_CODE_W = 16;
    localparam int DSOL_NUM_TERM = 2;

    // ************************************************************
    // Register offsets
    // ************************************************************
    localparam logic [7:0] DSOL_OFF_AT_SPEED_BAND = 8'h00;
    localparam logic [7:0] DSOL_OFF_FWD_THRESH = 8'h04;
    localparam logic [7:0] DSOL_OFF_REV_THRESH = 8'h08;
    localparam logic [7:0] DSOL_OFF_START_FREQ = 8'h0C;
    localparam logic [7:0] DSOL_OFF_SELECT_A = 8'h10;
    localparam logic [7:0] DSOL_OFF_SELECT_B = 8'h14;
    localparam logic [7:0] DSOL_OFF_STATUS = 8'h18;

    // ************************************************************
    // Reset values and setting limits
    // ************************************************************
    localparam logic [6:0] DSOL_BAND_RST = 7'h0A;
    localparam logic [6:0] DSOL_BAND_MAX = 7'h64;
    localparam logic [15:0] DSOL_FWD_RST = 16'h003C;
    localparam logic [15:0] DSOL_FREQ_MAX = 16'h0FA0;
    localparam logic [15:0] DSOL_REV_SAME = 16'h270F;
    localparam logic [15:0] DSOL_START_RST = 16'h0005;
    localparam logic [15:0] DSOL_NO_FUNC = 16'h270F;

    // ************************************************************
    // Terminal function codes
    // ************************************************************
    localparam logic [15:0] DSOL_CODE_NEG_BASE = 16'h0064;
    localparam logic [15:0] DSOL_CODE_MAX = 16'h00C7;
    localparam logic [15:0] DSOL_CODE_RUN = 16'h0000;
    localparam logic [15:0] DSOL_CODE_AT_SPEED = 16'h0001;
    localparam logic [15:0] DSOL_CODE_FREQ_THR = 16'h0004;
    localparam logic [15:0] DSOL_CODE_READY = 16'h000B;
    localparam logic [15:0] DSOL_CODE_INT_FAULT = 16'h005B;
    localparam logic [15:0] DSOL_CODE_ALARM = 16'h0063;
    localparam logic [15:0] DSOL_SEL_A_RST = 16'h0000;
    localparam logic [15:0] DSOL_SEL_B_RST = 16'h0063;

    // ************************************************************
    // Trip causes reported by the control core
    // ************************************************************
    typedef enum logic [7:0]
    {
        DSOL_FLT_NONE = 8'h00,
        DSOL_FLT_BRAKE_XSTR = 8'h01,
        DSOL_FLT_START_GND = 8'h02,
        DSOL_FLT_PHASE_LOSS = 8'h03,
        DSOL_FLT_PARAM_STORE = 8'h04,
        DSOL_FLT_PROCESSOR = 8'h05,
        DSOL_FLT_INRUSH = 8'h06,
        DSOL_FLT_ACCEL_OC = 8'h07,
        DSOL_FLT_OTHER = 8'hFF
    } dsol_fault_t;

    // ************************************************************
    // Carriers
    // ************************************************************
    typedef struct packed
    {
        logic [15:0] out_freq;
        logic [15:0] set_freq;
        logic rev_dir;
        logic init_done;
        logic trip;
        logic [7:0] fault_code;
        logic ground_fault_seen;
        logic dc_brake;
        logic power_fail;
        logic undervolt;
    } dsol_core_t;

    typedef struct packed
    {
        logic freq_threshold_flag;
        logic at_speed_flag;
        logic internal_fault_flag;
        logic trip_alarm_flag;
        logic motor_active_flag;
        logic operation_ready_flag;
    } dsol_flags_t;

endpackage

/* File: verilog/dsol_top.sv */
// Purpose: Status flags of a motor drive routed to two output terminals.
// Assumes: Core inputs share I_MCLK; the shutoff input is an external pin.
// Notes: Terminal A is the open collector, terminal B the relay contact.
//
// Function
// - Codes 0-99 conduct when function active; 100-199 conduct when inactive.
// - Same function may be selected on several terminals at once.
// - Operation ready asserted whenever the drive can run, also while running.
// - Motor active at output freq at or above start freq; off stopped or braking.
// - Ready selected by 11 or 111; motor active by 0 or 100.
// - Ready drops during power failure or undervoltage.
// - Open-collector terminal defaults to positive motor active.
// - Trip alarm asserted whenever the drive trips.
// - Trip alarm defaults to relay contact; codes 99 or 199 elsewhere.
// - Internal fault on circuit failure or wiring mistake; codes 91 or 191.
// - Internal fault for brake, ground, phase, storage, processor, inrush faults.
// - Acceleration overcurrent caused by start ground fault still flags internal fault.
// - At speed when output within band percent of set freq, default 10.
// - At speed selected by 1 or 101.
// - Threshold flag when output freq reaches forward threshold, default 6 Hz.
// - Reverse threshold used in reverse unless it is 9999.
// - Threshold flag selected by 4 or 104.
// - At speed and threshold flags off during DC injection braking.
// - Comparisons use output frequency before slip compensation.
//
// Decided for this implementation: the register offsets and the plain strobed port.

`timescale 1ns/1ps

module dsol_top
    import dsol_pkg::*;
(
    // Clock and reset
    input wire logic I_MCLK,
    input wire logic I_SYS_RST,
    // Register port
    input wire logic [DSOL_ADDR_W-1:0] I_ADDR,
    input wire logic [DSOL_DATA_W-1:0] I_WDATA,
    input wire logic I_WR,
    input wire logic I_RD,
    output logic [DSOL_DATA_W-1:0] O_RDATA,
    // Control core state
    input wire dsol_core_t I_CORE,
    // Shutoff pin
    input wire logic I_OUTPUT_SHUTOFF,
    // Status flags and terminals
    output dsol_flags_t O_FLAGS,
    output logic [DSOL_NUM_TERM-1:0] O_TERM_ON
);

    // ************************************************************
    // Functions
    // ************************************************************
    function automatic logic func_active(input logic [15:0] code, input dsol_flags_t f);
        logic [15:0] base;
        base = (code >= DSOL_CODE_NEG_BASE) ? code - DSOL_CODE_NEG_BASE : code;
        if (base == DSOL_CODE_RUN)
            func_active = f.motor_active_flag;
        else if (base == DSOL_CODE_AT_SPEED)
            func_active = f.at_speed_flag;
        else if (base == DSOL_CODE_FREQ_THR)
            func_active = f.freq_threshold_flag;
        else if (base == DSOL_CODE_READY)
            func_active = f.operation_ready_flag;
        else if (base == DSOL_CODE_INT_FAULT)
            func_active = f.internal_fault_flag;
        else if (base == DSOL_CODE_ALARM)
            func_active = f.trip_alarm_flag;
        else
            func_active = 1'b0;
    endfunction

    function automatic logic code_valid(input logic [15:0] code);
        code_valid = (code <= DSOL_CODE_MAX) || (code == DSOL_NO_FUNC);
    endfunction

    function automatic logic freq_valid(input logic [15:0] v);
        freq_valid = (v <= DSOL_FREQ_MAX);
    endfunction

    // ************************************************************
    // Declarations
    // ************************************************************
    logic shutoff_meta_q;
    logic shutoff_q;
    logic [6:0] band_q;
    logic [15:0] fwd_thr_q;
    logic [15:0] rev_thr_q;
    logic [15:0] start_freq_q;
    logic [15:0] sel_q [DSOL_NUM_TERM];
    logic [DSOL_DATA_W-1:0] rdata_d;
    logic [DSOL_DATA_W-1:0] rdata_q;
    dsol_flags_t flags_d;
    dsol_flags_t flags_q;
    logic [DSOL_NUM_TERM-1:0] term_d;
    logic [DSOL_NUM_TERM-1:0] term_q;
    logic [15:0] freq_diff;
    logic [23:0] diff_scaled;
    logic [23:0] band_limit;
    logic [15:0] active_thr;
    logic int_fault_cause;

    // ************************************************************
    // Shutoff pin synchroniser
    // ************************************************************
    always_ff @(posedge I_MCLK or posedge I_SYS_RST)
    begin
        if (I_SYS_RST)
        begin
            shutoff_meta_q <= 1'b0;
            shutoff_q <= 1'b0;
        end
        else
        begin
            shutoff_meta_q <= I_OUTPUT_SHUTOFF;
            shutoff_q <= shutoff_meta_q;
        end
    end

    // ************************************************************
    // Setting registers
    // ************************************************************
    always_ff @(posedge I_MCLK or posedge I_SYS_RST)
    begin
        if (I_SYS_RST)
        begin
            band_q <= DSOL_BAND_RST;
            fwd_thr_q <= DSOL_FWD_RST;
            rev_thr_q <= DSOL_REV_SAME;
            start_freq_q <= DSOL_START_RST;
        end
        else if (I_WR)
        begin
            // Out-of-range settings are ignored
            if (I_ADDR == DSOL_OFF_AT_SPEED_BAND)
            begin
                if (I_WDATA[31:0] <= {25'h0000000, DSOL_BAND_MAX})
                    band_q <= I_WDATA[6:0];
            end
            else if (I_ADDR == DSOL_OFF_FWD_THRESH)
            begin
                if (I_WDATA[31:16] == 16'h0000 && freq_valid(I_WDATA[15:0]))
                    fwd_thr_q <= I_WDATA[15:0];
            end
            else if (I_ADDR == DSOL_OFF_REV_THRESH)
            begin
                if (I_WDATA[31:16] == 16'h0000 &&
                    (freq_valid(I_WDATA[15:0]) || I_WDATA[15:0] == DSOL_REV_SAME))
                    rev_thr_q <= I_WDATA[15:0];
            end
            else if (I_ADDR == DSOL_OFF_START_FREQ)
            begin
                if (I_WDATA[31:16] == 16'h0000 && freq_valid(I_WDATA[15:0]))
                    start_freq_q <= I_WDATA[15:0];
            end
        end
    end

    // ************************************************************
    // Terminal function selectors
    // ************************************************************
    always_ff @(posedge I_MCLK or posedge I_SYS_RST)
    begin
        if (I_SYS_RST)
        begin
            sel_q[0] <= DSOL_SEL_A_RST;
            sel_q[1] <= DSOL_SEL_B_RST;
        end
        else if (I_WR && I_WDATA[31:16] == 16'h0000 && code_valid(I_WDATA[15:0]))
        begin
            // Selectors are independent, so one code may appear on both
            if (I_ADDR == DSOL_OFF_SELECT_A)
                sel_q[0] <= I_WDATA[15:0];
            else if (I_ADDR == DSOL_OFF_SELECT_B)
                sel_q[1] <= I_WDATA[15:0];
        end
    end

    // ************************************************************
    // Frequency comparisons
    // ************************************************************
    always_comb
    begin
        // Output frequency input is taken before slip compensation
        freq_diff = (I_CORE.out_freq >= I_CORE.set_freq) ?
                    I_CORE.out_freq - I_CORE.set_freq :
                    I_CORE.set_freq - I_CORE.out_freq;
        diff_scaled = 24'(freq_diff) * 24'h000064;
        band_limit = 24'(I_CORE.set_freq) * 24'(band_q);
        if (I_CORE.rev_dir && rev_thr_q != DSOL_REV_SAME)
            active_thr = rev_thr_q;
        else
            active_thr = fwd_thr_q;
    end

    // ************************************************************
    // Fault classification
    // ************************************************************
    always_comb
    begin
        int_fault_cause = 1'b0;
        case (dsol_fault_t'(I_CORE.fault_code))
            DSOL_FLT_BRAKE_XSTR,
            DSOL_FLT_START_GND,
            DSOL_FLT_PHASE_LOSS,
            DSOL_FLT_PARAM_STORE,
            DSOL_FLT_PROCESSOR,
            DSOL_FLT_INRUSH:
                int_fault_cause = 1'b1;
            DSOL_FLT_ACCEL_OC:
                int_fault_cause = I_CORE.ground_fault_seen;
            default:
                int_fault_cause = 1'b0;
        endcase
    end

    // ************************************************************
    // Status flags
    // ************************************************************
    always_comb
    begin
        flags_d.operation_ready_flag = I_CORE.init_done && !I_CORE.trip && !shutoff_q &&
                                       !I_CORE.power_fail && !I_CORE.undervolt;
        flags_d.motor_active_flag = (I_CORE.out_freq >= start_freq_q) &&
                                    (I_CORE.out_freq != 16'h0000) &&
                                    !I_CORE.dc_brake && !I_CORE.trip &&
                                    !shutoff_q;
        flags_d.trip_alarm_flag = I_CORE.trip;
        flags_d.internal_fault_flag = I_CORE.trip && int_fault_cause;
        flags_d.at_speed_flag = (diff_scaled <= band_limit) && !I_CORE.dc_brake;
        flags_d.freq_threshold_flag = (I_CORE.out_freq >= active_thr) &&
                                      !I_CORE.dc_brake;
    end

    always_ff @(posedge I_MCLK or posedge I_SYS_RST)
    begin
        if (I_SYS_RST)
            flags_q <= '0;
        else
            flags_q <= flags_d;
    end

    // ************************************************************
    // Terminal routing
    // ************************************************************
    generate
        for (genvar t = 0; t < DSOL_NUM_TERM; t++)
        begin : g_term
            always_comb
            begin
                if (sel_q[t] == DSOL_NO_FUNC)
                    term_d[t] = 1'b0;
                else if (sel_q[t] >= DSOL_CODE_NEG_BASE)
                    term_d[t] = !func_active(sel_q[t], flags_q);
                else
                    term_d[t] = func_active(sel_q[t], flags_q);
            end
        end
    endgenerate

    always_ff @(posedge I_MCLK or posedge I_SYS_RST)
    begin
        if (I_SYS_RST)
            term_q <= '0;
        else
            term_q <= term_d;
    end

    // ************************************************************
    // Register read
    // ************************************************************
    always_comb
    begin
        rdata_d = '0;
        if (I_RD)
        begin
            if (I_ADDR == DSOL_OFF_AT_SPEED_BAND)
                rdata_d = {25'h0000000, band_q};
            else if (I_ADDR == DSOL_OFF_FWD_THRESH)
                rdata_d = {16'h0000, fwd_thr_q};
            else if (I_ADDR == DSOL_OFF_REV_THRESH)
                rdata_d = {16'h0000, rev_thr_q};
            else if (I_ADDR == DSOL_OFF_START_FREQ)
                rdata_d = {16'h0000, start_freq_q};
            else if (I_ADDR == DSOL_OFF_SELECT_A)
                rdata_d = {16'h0000, sel_q[0]};
            else if (I_ADDR == DSOL_OFF_SELECT_B)
                rdata_d = {16'h0000, sel_q[1]};
            else if (I_ADDR == DSOL_OFF_STATUS)
                rdata_d = {23'h000000, shutoff_q, term_q, flags_q};
        end
    end

    always_ff @(posedge I_MCLK or posedge I_SYS_RST)
    begin
        if (I_SYS_RST)
            rdata_q <= '0;
        else
            rdata_q <= rdata_d;
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    assign O_RDATA = rdata_q;
    assign O_FLAGS = flags_q;
    assign O_TERM_ON = term_q;

endmodule
